// *** design/rtcc_regs.vh ***
`ifndef RTCC_REGS_VH
`define RTCC_REGS_VH

// ----------------------------------------------------------------
// Register offsets on the multiplexed address/data bus
// ----------------------------------------------------------------
`define RTCC_OFF_CONTROL 8'h0B
`define RTCC_OFF_FLAGS 8'h0C
`define RTCC_OFF_VALIDITY 8'h0D

// ----------------------------------------------------------------
// control_settings field positions
// ----------------------------------------------------------------
`define RTCC_CTL_INHIBIT 7
`define RTCC_CTL_PIE 6
`define RTCC_CTL_AIE 5
`define RTCC_CTL_UIE 4
`define RTCC_CTL_SQUARE_OUT_EN 3
`define RTCC_CTL_BIN 2
`define RTCC_CTL_H24 1
`define RTCC_CTL_DST 0

// ----------------------------------------------------------------
// interrupt_flags and contents_validity field positions
// ----------------------------------------------------------------
`define RTCC_FLG_PEND 7
`define RTCC_FLG_PER 6
`define RTCC_FLG_ALM 5
`define RTCC_FLG_UPD 4
`define RTCC_VAL_BIT 7

// ----------------------------------------------------------------
// Reset values of the reset-affected enables and flags
// ----------------------------------------------------------------
`define RTCC_RST_EN 1'h0
`define RTCC_RST_FLAGS 3'h0

// ----------------------------------------------------------------
// Alarm don't-care code and calendar constants (BCD / binary)
// ----------------------------------------------------------------
`define RTCC_DONT_CARE 2'h3
`define RTCC_SUNDAY 8'h01
`define RTCC_APR_BCD 8'h04
`define RTCC_APR_BIN 8'h04
`define RTCC_OCT_BCD 8'h10
`define RTCC_OCT_BIN 8'h0A
`define RTCC_APR_LAST_BCD 8'h24
`define RTCC_APR_LAST_BIN 8'h18
`define RTCC_OCT_LAST_BCD 8'h25
`define RTCC_OCT_LAST_BIN 8'h19
`define RTCC_HOUR_ONE 8'h01
`define RTCC_SIXTY_LESS_BCD 8'h59
`define RTCC_SIXTY_LESS_BIN 8'h3B

`endif

// *** design/rtcc_ctrl.v ***
// Contract
// - Inhibit clear lets counts advance each second
// - Inhibit bit untouched by reset or hardware
// - Periodic enable gates flag; reset clears it
// - Alarm enable gates alarm flag; reset clears
// - Alarm when time equals alarm, 11xxxxxx matches
// - Update enable cleared by reset or inhibit
// - Square output toggles when enabled, else low
// - Binary/BCD select changed only by software
// - 24/12 hour select changed only by software
// - April last Sunday skips 2 AM hour
// - October last Sunday repeats 1 AM once
// - No seasonal steps when disabled; not reset
// - Pending flag is OR of gated flags
// - Pending flag drives interrupt output low
// - Flags clear after read and during reset
// - Periodic flag sets on tap edge always
// - Alarm flag sets on match at update end always
// - Update-done flag sets after every update
// - Low four flag bits read zero
// - Validity bit low on power loss, read sets
// - Low seven validity bits read zero
// - Inhibit blocks updates, clears active flag
// - All don't-care alarm bytes fire each second
`timescale 1ns/1ns
`include "rtcc_regs.vh"

module rtcc_ctrl (
  // Clock and reset
  input wire REF_CLK,
  input wire RST_N,
  // Multiplexed address/data bus pins
  input wire [7:0] AD_IN,
  output reg [7:0] AD_OUT,
  output reg AD_OE,
  input wire ADDR_STROBE,
  input wire DATA_STROBE,
  input wire READ_NOT_WRITE,
  input wire CHIP_SEL_N,
  // Power sense pin
  input wire POWER_SENSE_PIN,
  // Divider taps and update sequencer (same clock)
  input wire PERIODIC_TAP,
  input wire SQUARE_TAP,
  input wire UPDATE_BUSY,
  input wire UPDATE_DONE,
  // Current time and alarm bytes
  input wire [7:0] TIME_SEC,
  input wire [7:0] TIME_MIN,
  input wire [7:0] TIME_HOUR,
  input wire [7:0] TIME_WEEKDAY,
  input wire [7:0] TIME_DATE,
  input wire [7:0] TIME_MONTH,
  input wire [7:0] ALARM_SEC,
  input wire [7:0] ALARM_MIN,
  input wire [7:0] ALARM_HOUR,
  // Controls to the time counter chain
  output reg UPDATE_INHIBIT,
  output reg UPDATE_ACTIVE,
  output reg BINARY_FORMAT_SEL,
  output reg HOUR_FORMAT_SEL,
  output reg SPRING_SKIP,
  output reg FALL_BACK,
  // Interrupt and square-wave pins
  output reg INTERRUPT_REQ_N,
  output reg SQUARE_OUT_PIN
);

  // ----------------------------------------------------------------
  // Alarm byte compare with don't-care code
  // ----------------------------------------------------------------
  function byte_match;
    input [7:0] now_b;
    input [7:0] alm_b;
    begin
      byte_match = (alm_b[7:6] == `RTCC_DONT_CARE) || (alm_b == now_b);
    end
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  reg [7:0] ad_meta_reg;
  reg [7:0] ad_sync_reg;
  reg [3:0] ctl_meta_reg;
  reg [3:0] ctl_sync_reg;
  reg ps_meta_reg;
  reg ps_sync_reg;
  reg as_prev_reg;
  reg ds_prev_reg;

  // Two flops on every pin; only the second stage is read
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      ad_meta_reg <= 8'h00;
      ad_sync_reg <= 8'h00;
      ctl_meta_reg <= 4'h8;
      ctl_sync_reg <= 4'h8;
      as_prev_reg <= 1'b0;
      ds_prev_reg <= 1'b0;
    end else begin
      ad_meta_reg <= AD_IN;
      ad_sync_reg <= ad_meta_reg;
      ctl_meta_reg <= {CHIP_SEL_N, READ_NOT_WRITE, DATA_STROBE, ADDR_STROBE};
      ctl_sync_reg <= ctl_meta_reg;
      as_prev_reg <= ctl_sync_reg[0];
      ds_prev_reg <= ctl_sync_reg[1];
    end
  end

  // Power sense is kept out of the reset so the validity bit survives it
  always @(posedge REF_CLK) begin
    ps_meta_reg <= POWER_SENSE_PIN;
    ps_sync_reg <= ps_meta_reg;
  end

  wire as_s = ctl_sync_reg[0];
  wire ds_s = ctl_sync_reg[1];
  wire rw_s = ctl_sync_reg[2];
  wire cs_n_s = ctl_sync_reg[3];
  wire as_fall = as_prev_reg & ~as_s;
  wire ds_rise = ~ds_prev_reg & ds_s;
  wire ds_fall = ds_prev_reg & ~ds_s;

  // ----------------------------------------------------------------
  // Address latch and access decode
  // ----------------------------------------------------------------
  reg [7:0] addr_reg;

  // Address is taken from the bus as the address strobe falls
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      addr_reg <= 8'h00;
    end else if (as_fall) begin
      addr_reg <= ad_sync_reg;
    end
  end

  reg hit_ctl;
  reg hit_flg;
  reg hit_val;
  always @* begin
    hit_ctl = 1'b0;
    hit_flg = 1'b0;
    hit_val = 1'b0;
    if (addr_reg == `RTCC_OFF_CONTROL) begin
      hit_ctl = 1'b1;
    end else if (addr_reg == `RTCC_OFF_FLAGS) begin
      hit_flg = 1'b1;
    end else if (addr_reg == `RTCC_OFF_VALIDITY) begin
      hit_val = 1'b1;
    end
  end
  wire hit_any = hit_ctl | hit_flg | hit_val;
  wire wr_ev = ds_fall & ~rw_s & ~cs_n_s;
  wire rd_start = ds_rise & rw_s & ~cs_n_s & hit_any;
  // Flags clear at the end of the read, after the data was captured
  wire flg_rd_end = ds_fall & rw_s & ~cs_n_s & hit_flg;
  wire val_rd = rd_start & hit_val;

  // ----------------------------------------------------------------
  // control_settings
  // ----------------------------------------------------------------
  reg inhibit_reg;
  reg bin_reg;
  reg h24_reg;
  reg dst_reg;
  reg pie_reg;
  reg aie_reg;
  reg uie_reg;
  reg square_out_en_reg;
  reg inhibit_prev_reg;

  always @(posedge REF_CLK) begin
    inhibit_prev_reg <= inhibit_reg;
    if (wr_ev && hit_ctl) begin
      inhibit_reg <= ad_sync_reg[`RTCC_CTL_INHIBIT];
      bin_reg <= ad_sync_reg[`RTCC_CTL_BIN];
      h24_reg <= ad_sync_reg[`RTCC_CTL_H24];
      dst_reg <= ad_sync_reg[`RTCC_CTL_DST];
    end
  end

  wire inhibit_rise = inhibit_reg & ~inhibit_prev_reg;

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pie_reg <= `RTCC_RST_EN;
      aie_reg <= `RTCC_RST_EN;
      uie_reg <= `RTCC_RST_EN;
      square_out_en_reg <= `RTCC_RST_EN;
    end else begin
      if (wr_ev && hit_ctl) begin
        pie_reg <= ad_sync_reg[`RTCC_CTL_PIE];
        aie_reg <= ad_sync_reg[`RTCC_CTL_AIE];
        uie_reg <= ad_sync_reg[`RTCC_CTL_UIE];
        square_out_en_reg <= ad_sync_reg[`RTCC_CTL_SQUARE_OUT_EN];
      end
      if (inhibit_rise) begin
        uie_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Alarm and seasonal-step detection on the current time
  // ----------------------------------------------------------------
  // three-byte alarm compare
  wire alarm_hit = byte_match(TIME_SEC, ALARM_SEC) & byte_match(TIME_MIN, ALARM_MIN) &
                   byte_match(TIME_HOUR, ALARM_HOUR);

  wire [7:0] max_ms = bin_reg ? `RTCC_SIXTY_LESS_BIN : `RTCC_SIXTY_LESS_BCD;
  wire [7:0] apr_m = bin_reg ? `RTCC_APR_BIN : `RTCC_APR_BCD;
  wire [7:0] oct_m = bin_reg ? `RTCC_OCT_BIN : `RTCC_OCT_BCD;
  wire [7:0] apr_last = bin_reg ? `RTCC_APR_LAST_BIN : `RTCC_APR_LAST_BCD;
  wire [7:0] oct_last = bin_reg ? `RTCC_OCT_LAST_BIN : `RTCC_OCT_LAST_BCD;
  // Hour byte for 1 AM is the same in both hour modes (PM bit clear)
  wire at_0159 = (TIME_HOUR == `RTCC_HOUR_ONE) && (TIME_MIN == max_ms) && (TIME_SEC == max_ms);
  wire sunday = (TIME_WEEKDAY == `RTCC_SUNDAY);
  wire apr_day = sunday && (TIME_MONTH == apr_m) && (TIME_DATE >= apr_last);
  wire oct_day = sunday && (TIME_MONTH == oct_m) && (TIME_DATE >= oct_last);

  reg fell_back_reg;

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      SPRING_SKIP <= 1'b0;
      FALL_BACK <= 1'b0;
      fell_back_reg <= 1'b0;
    end else begin
      SPRING_SKIP <= dst_reg & apr_day & at_0159;
      FALL_BACK <= dst_reg & oct_day & at_0159 & ~fell_back_reg;
      // Held through the whole first 01:59:59 so the chain sees it at the next update;
      // remembered once that second is left, dropped once the day is over
      if (FALL_BACK && !at_0159) begin
        fell_back_reg <= 1'b1;
      end else if (!oct_day) begin
        fell_back_reg <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt flags
  // ----------------------------------------------------------------
  reg per_flag_reg;
  reg alm_flag_reg;
  reg upd_flag_reg;
  reg tap_prev_reg;

  wire per_set = PERIODIC_TAP & ~tap_prev_reg;
  wire alm_set = UPDATE_DONE & alarm_hit;

  // update end sets flag
  // A set in the clearing cycle wins, so that event is not lost
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      per_flag_reg <= 1'b0;
      alm_flag_reg <= 1'b0;
      upd_flag_reg <= 1'b0;
      tap_prev_reg <= 1'b0;
    end else begin
      tap_prev_reg <= PERIODIC_TAP;
      per_flag_reg <= per_set | (per_flag_reg & ~flg_rd_end);
      alm_flag_reg <= alm_set | (alm_flag_reg & ~flg_rd_end);
      upd_flag_reg <= UPDATE_DONE | (upd_flag_reg & ~flg_rd_end);
    end
  end

  wire pending = (per_flag_reg & pie_reg) | (alm_flag_reg & aie_reg) | (upd_flag_reg & uie_reg);

  // ----------------------------------------------------------------
  // contents_validity
  // ----------------------------------------------------------------
  reg valid_reg;

  always @(posedge REF_CLK) begin
    if (!ps_sync_reg) begin
      valid_reg <= 1'b0;
    end else if (val_rd) begin
      valid_reg <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Read data mux
  // ----------------------------------------------------------------
  reg [7:0] rd_data;
  always @* begin
    rd_data = 8'h00;
    if (hit_ctl) begin
      rd_data = {inhibit_reg, pie_reg, aie_reg, uie_reg, square_out_en_reg, bin_reg, h24_reg, dst_reg};
    end else if (hit_flg) begin
      rd_data = {pending, per_flag_reg, alm_flag_reg, upd_flag_reg, 4'h0};
    end else if (hit_val) begin
      rd_data = {valid_reg, 7'h00};
    end
  end

  // data captured before clear
  // Bus drive only while the strobe is high on a mapped read
  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      AD_OUT <= 8'h00;
      AD_OE <= 1'b0;
    end else begin
      if (rd_start) begin
        AD_OUT <= rd_data;
        AD_OE <= 1'b1;
      end else if (!ds_s || cs_n_s) begin
        AD_OE <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs to the counter chain and pins
  // ----------------------------------------------------------------
  // Copies skip reset like their bits, so the chain never sees them drop
  always @(posedge REF_CLK) begin
    UPDATE_INHIBIT <= inhibit_reg;
    BINARY_FORMAT_SEL <= bin_reg;
    HOUR_FORMAT_SEL <= h24_reg;
  end

  always @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      UPDATE_ACTIVE <= 1'b0;
      INTERRUPT_REQ_N <= 1'b1;
      SQUARE_OUT_PIN <= 1'b0;
    end else begin
      UPDATE_ACTIVE <= UPDATE_BUSY & ~inhibit_reg;
      INTERRUPT_REQ_N <= ~pending;
      SQUARE_OUT_PIN <= square_out_en_reg & SQUARE_TAP;
    end
  end

endmodule // rtcc_ctrl

// *** tb/rtcc_checker.sv ***
`timescale 1ns/1ns
`include "rtcc_regs.vh"
// ----
// Port checker
// ----
module rtcc_checker (
  // Clock and reset
  input wire REF_CLK,
  input wire RST_N,
  // Watched pins
  input wire [7:0] TIME_MIN,
  input wire [7:0] TIME_HOUR,
  input wire [7:0] TIME_WEEKDAY,
  input wire [7:0] TIME_MONTH,
  input wire DATA_STROBE,
  input wire READ_NOT_WRITE,
  input wire CHIP_SEL_N,
  input wire AD_OE,
  input wire SQUARE_TAP,
  input wire SQUARE_OUT_PIN,
  input wire UPDATE_BUSY,
  input wire UPDATE_INHIBIT,
  input wire UPDATE_ACTIVE,
  input wire SPRING_SKIP,
  input wire FALL_BACK,
  input wire INTERRUPT_REQ_N
);
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_N);
  // Strobe low at four edges in a row: two sync stages plus the output flop
  sequence s_ds_idle;
    !DATA_STROBE [*4];
  endsequence
  // Sunday 1 AM at :59 minutes one edge ago, in either number format
  sequence s_one_fifty_nine;
    $past(TIME_WEEKDAY) == `RTCC_SUNDAY && $past(TIME_HOUR) == `RTCC_HOUR_ONE &&
      ($past(TIME_MIN) == `RTCC_SIXTY_LESS_BCD || $past(TIME_MIN) == `RTCC_SIXTY_LESS_BIN);
  endsequence
  property p_sq_low;
    !SQUARE_TAP |=> !SQUARE_OUT_PIN;
  endproperty
  a_sq_low: assert property (p_sq_low) else $error("square output high without its tap");
  // Drive starts only on a selected read strobe rise seen through the synchroniser
  property p_oe_start;
    $rose(AD_OE) |-> $past(DATA_STROBE, 3) && !$past(DATA_STROBE, 4) &&
      $past(READ_NOT_WRITE, 3) && !$past(CHIP_SEL_N, 3);
  endproperty
  a_oe_start: assert property (p_oe_start) else $error("bus driven without a read strobe");
  property p_oe_release;
    s_ds_idle |-> !AD_OE;
  endproperty
  a_oe_release: assert property (p_oe_release) else $error("bus still driven with strobe idle");
  property p_active_inh;
    UPDATE_INHIBIT |-> !UPDATE_ACTIVE;
  endproperty
  a_active_inh: assert property (p_active_inh) else $error("update active while inhibited");
  // The reset edge itself is skipped: the active flag is cleared there
  property p_active_run;
    $past(RST_N) && $past(UPDATE_BUSY) && !UPDATE_INHIBIT |-> UPDATE_ACTIVE;
  endproperty
  a_active_run: assert property (p_active_run) else $error("update blocked without inhibit");
  property p_irq_reset;
    !$past(RST_N) |-> INTERRUPT_REQ_N;
  endproperty
  a_irq_reset: assert property (p_irq_reset) else $error("interrupt low straight after reset");
  property p_spring;
    SPRING_SKIP |-> s_one_fifty_nine ##0 $past(TIME_MONTH) == `RTCC_APR_BCD;
  endproperty
  a_spring: assert property (p_spring) else $error("spring step outside its instant");
  property p_fall;
    FALL_BACK |-> s_one_fifty_nine ##0 ($past(TIME_MONTH) == `RTCC_OCT_BCD || $past(TIME_MONTH) == `RTCC_OCT_BIN);
  endproperty
  a_fall: assert property (p_fall) else $error("fall step outside its instant");
endmodule // rtcc_checker

bind rtcc_ctrl rtcc_checker i_rtcc_checker (
  .REF_CLK(REF_CLK),
  .RST_N(RST_N),
  .TIME_MIN(TIME_MIN),
  .TIME_HOUR(TIME_HOUR),
  .TIME_WEEKDAY(TIME_WEEKDAY),
  .TIME_MONTH(TIME_MONTH),
  .DATA_STROBE(DATA_STROBE),
  .READ_NOT_WRITE(READ_NOT_WRITE),
  .CHIP_SEL_N(CHIP_SEL_N),
  .AD_OE(AD_OE),
  .SQUARE_TAP(SQUARE_TAP),
  .SQUARE_OUT_PIN(SQUARE_OUT_PIN),
  .UPDATE_BUSY(UPDATE_BUSY),
  .UPDATE_INHIBIT(UPDATE_INHIBIT),
  .UPDATE_ACTIVE(UPDATE_ACTIVE),
  .SPRING_SKIP(SPRING_SKIP),
  .FALL_BACK(FALL_BACK),
  .INTERRUPT_REQ_N(INTERRUPT_REQ_N)
);

// *** tb/rtcc_host.sv ***
`timescale 1ns/1ns
// ----
// Host processor on the multiplexed bus
// ----
module rtcc_host (
  // Clock and returned bus
  input wire clk,
  input wire [7:0] ad_dev,
  input wire ad_oe,
  // Host-driven pins
  output reg [7:0] ad_drv,
  output reg as_o,
  output reg ds_o,
  output reg rnw,
  output reg cs_n
);
  // Idle bus: strobes low, chip deselected
  initial begin
    ad_drv = 8'h00;
    as_o = 1'b0;
    ds_o = 1'b0;
    rnw = 1'b1;
    cs_n = 1'b1;
  end
  // strobes low idle
  // One address phase then one data phase, each strobe held 4+ cycles
  task xfer(input logic rd, input logic [7:0] a, input logic [7:0] wd, output logic [7:0] q,
            output logic seen);
    integer n;
    begin
      seen = 1'b0;
      q = 8'h00;
      @(posedge clk);
      cs_n <= 1'b0;
      rnw <= rd;
      as_o <= 1'b1;
      ad_drv <= a;
      repeat (4) @(posedge clk);
      as_o <= 1'b0;
      repeat (4) @(posedge clk);
      ds_o <= 1'b1;
      // Released during reads: inverse of the last value, never a stale copy
      ad_drv <= rd ? ~a : wd;
      for (n = 0; n < 8; n = n + 1) begin
        @(posedge clk);
        if (ad_oe === 1'b1 && !seen) begin
          seen = 1'b1;
          q = ad_dev;
        end
      end
      ds_o <= 1'b0;
      repeat (6) @(posedge clk);
      cs_n <= 1'b1;
      ad_drv <= ~ad_drv;
    end
  endtask
endmodule // rtcc_host

// *** tb/rtcc_ctrl_bench.sv ***
`timescale 1ns/1ns
`define CHK(nm, e, a) begin cmp_count = cmp_count + 1; if ((a) !== (e)) begin fails = fails + 1; \
  $display("[ERR] %s expected %h seen %h", nm, e, a); end end
module rtcc_ctrl_bench;
  reg ref_clk, rst_n, ps, per_tap, sq_tap, busy, done;
  reg [7:0] tm [0:5];
  reg [7:0] al [0:2];
  wire [7:0] ad_out, host_drv, ad_bus;
  wire ad_oe, as_w, ds_w, rnw_w, cs_w, inh, act, bin, h24, spring, fall, irq_n, sq;
  reg [7:0] q;
  reg seen;
  integer fails, cmp_count, i;
  // Bus wire: device drives while its enable is high
  assign ad_bus = ad_oe ? ad_out : host_drv;
  rtcc_host i_rtcc_host (.clk(ref_clk), .ad_dev(ad_bus), .ad_oe(ad_oe), .ad_drv(host_drv),
    .as_o(as_w), .ds_o(ds_w), .rnw(rnw_w), .cs_n(cs_w));
  rtcc_ctrl i_rtcc_ctrl (.REF_CLK(ref_clk), .RST_N(rst_n), .AD_IN(ad_bus), .AD_OUT(ad_out),
    .AD_OE(ad_oe), .ADDR_STROBE(as_w), .DATA_STROBE(ds_w), .READ_NOT_WRITE(rnw_w),
    .CHIP_SEL_N(cs_w), .POWER_SENSE_PIN(ps), .PERIODIC_TAP(per_tap), .SQUARE_TAP(sq_tap),
    .UPDATE_BUSY(busy), .UPDATE_DONE(done), .TIME_SEC(tm[0]), .TIME_MIN(tm[1]),
    .TIME_HOUR(tm[2]), .TIME_WEEKDAY(tm[3]), .TIME_DATE(tm[4]), .TIME_MONTH(tm[5]),
    .ALARM_SEC(al[0]), .ALARM_MIN(al[1]), .ALARM_HOUR(al[2]), .UPDATE_INHIBIT(inh),
    .UPDATE_ACTIVE(act), .BINARY_FORMAT_SEL(bin), .HOUR_FORMAT_SEL(h24), .SPRING_SKIP(spring),
    .FALL_BACK(fall), .INTERRUPT_REQ_N(irq_n), .SQUARE_OUT_PIN(sq));
  // ----
  // Tasks
  // ----
  task tick(input integer n);
    repeat (n) @(posedge ref_clk);
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    i_rtcc_host.xfer(1'b0, a, d, q, seen);
  endtask
  // Masked read compare; unknown reset bits are masked off
  task rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    i_rtcc_host.xfer(1'b1, a, 8'h00, q, seen);
    `CHK("read data", e, q & m)
  endtask
  task pulse(input logic per);
    @(posedge ref_clk);
    if (per) per_tap <= 1'b1; else done <= 1'b1;
    @(posedge ref_clk);
    per_tap <= 1'b0;
    done <= 1'b0;
    tick(3);
  endtask
  // Time bytes sec, min, hour, weekday, date, month
  task set_time(input logic [47:0] v);
    @(posedge ref_clk);
    for (i = 0; i < 6; i = i + 1) tm[i] <= v[47 - 8 * i -: 8];
    tick(3);
  endtask
  task tdone(input integer n);
    $display("test %0d done", n);
  endtask
  task final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Free-running 50 MHz clock
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  // Hang guard, well beyond the expected run length
  initial begin
    tick(20000);
    fails = fails + 1;
    final_report;
  end
  // ----
  // Tests
  // ----
  initial begin
    fails = 0;
    cmp_count = 0;
    {rst_n, per_tap, sq_tap, busy, done} = 5'h00;
    ps = 1'b1;
    for (i = 0; i < 6; i = i + 1) tm[i] = 8'h00;
    for (i = 0; i < 3; i = i + 1) al[i] = 8'h11;
    tick(16);
    rst_n <= 1'b1;
    tick(4);
    rdc(8'h0B, 8'h78, 8'h00);
    rdc(8'h0C, 8'hFF, 8'h00);
    `CHK("irq", 1'b1, irq_n)
    tdone(1);
    wr(8'h0B, 8'h87);
    pulse(1'b0);
    rst_n <= 1'b0;
    tick(3);
    rst_n <= 1'b1;
    tick(4);
    rdc(8'h0B, 8'hFF, 8'h87);
    `CHK("format", 3'h7, {inh, bin, h24})
    busy <= 1'b1;
    tick(3);
    `CHK("active", 1'b0, act)
    wr(8'h0B, 8'h07);
    `CHK("active", 1'b1, act)
    busy <= 1'b0;
    wr(8'h0B, 8'h17);
    wr(8'h0B, 8'h97);
    rdc(8'h0B, 8'hF0, 8'h80);
    wr(8'h0B, 8'h03);
    tdone(2);
    pulse(1'b1);
    `CHK("irq", 1'b1, irq_n)
    rdc(8'h0C, 8'hFF, 8'h40);
    rdc(8'h0C, 8'hFF, 8'h00);
    wr(8'h0B, 8'h43);
    pulse(1'b1);
    `CHK("irq", 1'b0, irq_n)
    rdc(8'h0C, 8'hFF, 8'hC0);
    `CHK("irq", 1'b1, irq_n)
    tdone(3);
    set_time(48'h56_34_12_03_10_06);
    for (i = 0; i < 3; i = i + 1) al[i] <= tm[i];
    wr(8'h0B, 8'h33);
    pulse(1'b0);
    rdc(8'h0C, 8'hFF, 8'hB0);
    al[0] <= 8'h57;
    pulse(1'b0);
    rdc(8'h0C, 8'hFF, 8'h90);
    for (i = 0; i < 3; i = i + 1) al[i] <= 8'hC0;
    pulse(1'b0);
    rdc(8'h0C, 8'hFF, 8'hB0);
    wr(8'h0B, 8'h03);
    pulse(1'b0);
    `CHK("irq", 1'b1, irq_n)
    rdc(8'h0C, 8'hFF, 8'h30);
    tdone(4);
    sq_tap <= 1'b1;
    wr(8'h0B, 8'h0B);
    `CHK("square", 1'b1, sq)
    sq_tap <= 1'b0;
    tick(3);
    `CHK("square", 1'b0, sq)
    sq_tap <= 1'b1;
    wr(8'h0B, 8'h03);
    `CHK("square", 1'b0, sq)
    tdone(5);
    set_time(48'h59_59_01_01_25_04);
    `CHK("spring", 1'b1, spring)
    set_time(48'h59_59_01_01_25_10);
    `CHK("fall", 2'h1, {spring, fall})
    wr(8'h0B, 8'h02);
    `CHK("fall", 1'b0, fall)
    wr(8'h0B, 8'h03);
    set_time(48'h00_00_01_01_25_10);
    set_time(48'h59_59_01_01_25_10);
    `CHK("fall once", 1'b0, fall)
    wr(8'h0B, 8'h07);
    set_time(48'h3B_3B_01_01_18_04);
    `CHK("spring bin", 1'b1, spring)
    tdone(6);
    ps <= 1'b0;
    tick(4);
    rdc(8'h0D, 8'hFF, 8'h00);
    ps <= 1'b1;
    tick(4);
    rdc(8'h0D, 8'hFF, 8'h00);
    wr(8'h0D, 8'h7F);
    rdc(8'h0D, 8'hFF, 8'h80);
    pulse(1'b0);
    wr(8'h0C, 8'h0F);
    rdc(8'h0C, 8'hFF, 8'h30);
    i_rtcc_host.xfer(1'b1, 8'h3F, 8'h00, q, seen);
    `CHK("unmapped drive", 1'b0, seen)
    tdone(7);
    final_report;
  end
endmodule // rtcc_ctrl_bench
